// [common/mra_pkg.sv]
// Purpose: shared constants of the monitor register-access block
// Assumes: 20 MHz core clock, APB byte addresses, 8-bit register data
// Notes: all offsets are word aligned byte addresses
package mra_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_SLEEP = 8'h04;
  localparam logic [7:0] OFF_SLPMSK = 8'h08;
  localparam logic [7:0] OFF_OTHMSK = 8'h0c;
  localparam logic [7:0] OFF_MCST = 8'h10;
  localparam logic [7:0] OFF_HOSTST = 8'h14;
  localparam logic [7:0] OFF_LIMIT = 8'h18;
  localparam logic [7:0] OFF_ADDRST = 8'h1c;
  localparam logic [7:0] OFF_W16_BASE = 8'h20;
  localparam logic [7:0] OFF_W16_END = 8'h2c;
  localparam logic [7:0] OFF_VAL_BASE = 8'h40;
  localparam logic [7:0] OFF_VAL_END = 8'h90;
  localparam logic [7:0] OFF_ID = 8'hfc;
  // ==========================================================
  // configuration fields
  localparam int CFG_LOCK = 0;
  localparam int CFG_GLOBAL_EVENT_MASK_BIT = 1;
  localparam int CFG_ALERT_STD = 2;
  localparam int CFG_START = 3;
  localparam int CFG_DIODE1B = 4;
  localparam int CFG_DIODE2B = 5;
  localparam int ADDRST_VLD = 7;
  // ==========================================================
  // reset values
  localparam logic [7:0] LIMIT_RST = 8'hff;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [15:0] W16_RST = 16'h0000;
  localparam logic [2:0] SLEEP_RUN = 3'h0;
  localparam logic [2:0] DEEPEST_SLEEP_STATE = 3'h5;
  localparam logic [7:0] DEEP_FIXED_MASK = 8'hf0;
  // factory identification, value arbitrary
  localparam logic [7:0] FACTORY_ID = 8'h5a;
  // ==========================================================
  // slave address selection
  localparam logic [1:0] ASEL_LOW = 2'h0;
  localparam logic [1:0] ASEL_MID = 2'h1;
  localparam logic [1:0] ASEL_HIGH = 2'h2;
  localparam logic [6:0] SADDR_LOW = 7'h2c;
  localparam logic [6:0] SADDR_MID = 7'h2e;
  localparam logic [6:0] SADDR_HIGH = 7'h2d;
  // ==========================================================
  // conversion sequence
  localparam int NUM_SLOTS = 21;
  localparam logic [4:0] SLOT_Z1B = 5'h02;
  localparam logic [4:0] SLOT_Z2B = 5'h04;
  localparam logic [4:0] SLOT_LAST = 5'h14;
  // ==========================================================
  // timing
  localparam int CLK_NS = 50;
  localparam int EXT_APPLY_US = 10;
  localparam int EXT_DETECT_US = 4;
  localparam int POR_DRIVE_US = 20;
  localparam int ROUND_MS = 100;
  localparam int EXT_APPLY_CYC = (EXT_APPLY_US * 1000) / CLK_NS;
  localparam int EXT_DETECT_CYC = (EXT_DETECT_US * 1000) / CLK_NS;
  localparam int POR_DRIVE_CYC = (POR_DRIVE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SLOT_CYC = (ROUND_MS * 1000000 / CLK_NS) / NUM_SLOTS;
endpackage

// [core/mra_rstdet.sv]
// Purpose: external reset pin detector with qualified delay
// Assumes: pin is asynchronous to the core clock
// Notes: apply pulse comes a fixed time after the synchronised assertion
`timescale 1ns/1ps
module mra_rstdet (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_pin_b,
  output logic o_apply
);
  logic sync1_r;
  logic sync2_r;
  logic run_r;
  logic run_nxt;
  logic done_r;
  logic done_nxt;
  logic apply_r;
  logic apply_nxt;
  logic [8:0] cnt_r;
  logic [8:0] cnt_nxt;

  // ==========================================================
  // pulse qualification and delay
  always_comb begin
    run_nxt = run_r;
    done_nxt = done_r;
    cnt_nxt = cnt_r;
    apply_nxt = 1'b0;
    if (done_r) begin
      if (sync2_r) begin
        done_nxt = 1'b0;
      end
    end else if (!run_r) begin
      if (!sync2_r) begin
        run_nxt = 1'b1;
        cnt_nxt = 9'h001;
      end
    end else if (sync2_r && cnt_r < 9'(mra_pkg::EXT_DETECT_CYC)) begin
      run_nxt = 1'b0; // short glitch dropped [R11]
    end else if (cnt_r == 9'(mra_pkg::EXT_APPLY_CYC)) begin
      apply_nxt = 1'b1; // [R09] [R10]
      run_nxt = 1'b0;
      done_nxt = !sync2_r;
    end else begin
      cnt_nxt = cnt_r + 9'h001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      run_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r <= 9'h000;
      apply_r <= 1'b0;
    end else begin
      sync1_r <= i_pin_b;
      sync2_r <= sync1_r;
      run_r <= run_nxt;
      done_r <= done_nxt;
      cnt_r <= cnt_nxt;
      apply_r <= apply_nxt;
    end
  end

  assign o_apply = apply_r;
endmodule

// [core/mra_top.sv]
// Purpose: register access and status logic of a hardware monitor
// Assumes: APB slave, zero wait states, I_EVENT on the core clock
// Notes: reset pin is open drain, resolved outside this module
// Behaviour
// R01: reading a 16-bit low byte freezes that register's high byte.
// R02: reading the frozen high byte releases the freeze.
// R03: low-byte read of another register moves the freeze there.
// R04: low-byte write is buffered until its high byte is written.
// R05: low-byte write to another register drops the earlier buffered byte.
// R06: high-byte write without a buffered low byte is refused.
// R07: masters should not interleave 16-bit register reads.
// R08: at power-up drive reset pin low, then release it.
// R09: ten microseconds after reset pin assertion, lock bit clears.
// R10: ten microseconds after reset pin assertion, sleep state goes deepest.
// R11: reset pulses longer than four microseconds are always detected.
// R12: power-on reset initialises all groups except measured values.
// R13: external reset touches only lock bit and sleep state; the code also drops the freeze and the buffered low byte.
// R14: first bus access samples tri-level select and fixes slave address.
// R15: round-robin conversion starts at power-up, fixed order, bounded cycle.
// R16: conversion results land in value registers, readable anytime.
// R17: error status bits stay set until software clears them.
// R18: writing one clears a status bit only if its event is gone.
// R19: management and host status copies clear independently.
// R20: alert-standard mode makes management status clear on read.
// R21: software programs limits and masks before start and sleep zero.
// R22: masked events never set status, masking never clears status.
// R23: either reset drops the freeze and the buffered low byte.
`timescale 1ns/1ps
module mra_top #(
  parameter int P_SLOT_CYC = mra_pkg::SLOT_CYC
) (
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_RSTPIN_B,
  output logic O_RSTPIN_B,
  output logic O_RSTPIN_OE,
  input wire logic [1:0] I_ADDR_SEL,
  output logic [6:0] O_SLAVE_ADDR,
  output logic O_SLAVE_ADDR_VLD,
  input wire logic [7:0] I_EVENT,
  input wire logic [7:0] I_CONV_DATA,
  output logic [4:0] O_CONV_CHAN
);
  typedef enum logic [1:0] {
    ST_DRIVE = 2'b01,
    ST_RUN = 2'b10
  } mra_pin_t;

  // decode of a 16-bit register byte: {hit, index, high}
  function automatic logic [2:0] w16_dec(input logic [7:0] a);
    logic hit;
    hit = (a >= mra_pkg::OFF_W16_BASE) && (a <= mra_pkg::OFF_W16_END) && (a[1:0] == 2'b00);
    w16_dec = {hit, a[3], a[2]};
  endfunction

  logic setup;
  logic acc_wr;
  logic acc_rd;
  logic [2:0] dec;
  logic ext_apply;
  logic [7:0] wd;

  assign setup = I_PSEL && !I_PENABLE;
  assign acc_wr = I_PSEL && I_PENABLE && I_PWRITE;
  assign acc_rd = I_PSEL && I_PENABLE && !I_PWRITE;
  assign dec = w16_dec(I_PADDR);
  assign wd = I_PWDATA[7:0];
  assign O_PREADY = 1'b1;

  mra_rstdet u_rstdet (
    .i_clk(I_MCLK),
    .i_rst_b(I_RST_B),
    .i_pin_b(I_RSTPIN_B),
    .o_apply(ext_apply)
  );

  // ==========================================================
  // power-on drive of the reset pin
  mra_pin_t pin_st_r;
  mra_pin_t pin_st_nxt;
  logic [8:0] drv_cnt_r;
  logic [8:0] drv_cnt_nxt;

  always_comb begin
    pin_st_nxt = pin_st_r;
    drv_cnt_nxt = drv_cnt_r;
    case (pin_st_r)
      ST_DRIVE: begin
        if (drv_cnt_r == 9'(mra_pkg::POR_DRIVE_CYC - 1)) begin
          pin_st_nxt = ST_RUN; // [R08]
        end else begin
          drv_cnt_nxt = drv_cnt_r + 9'h001;
        end
      end
      ST_RUN: begin
        pin_st_nxt = ST_RUN;
      end
      default: begin
        pin_st_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pin_st_r <= ST_DRIVE;
      drv_cnt_r <= 9'h000;
    end else begin
      pin_st_r <= pin_st_nxt;
      drv_cnt_r <= drv_cnt_nxt;
    end
  end

  assign O_RSTPIN_B = 1'b0;
  assign O_RSTPIN_OE = (pin_st_r == ST_DRIVE); // [R08]

  // ==========================================================
  // configuration, masks, limits, slave address
  logic lock_r, lock_nxt, global_event_mask_bit_r, global_event_mask_bit_nxt, start_r, start_nxt;
  logic astd_r, astd_nxt, d1b_r, d1b_nxt, d2b_r, d2b_nxt;
  logic [2:0] sleep_r, sleep_nxt;
  logic [7:0] slpmsk_r, slpmsk_nxt, othmsk_r, othmsk_nxt, limit_r, limit_nxt;
  logic [1:0] asel1_r, asel2_r;
  logic [6:0] saddr_r, saddr_nxt;
  logic saddr_vld_r, saddr_vld_nxt;

  always_comb begin
    {lock_nxt, global_event_mask_bit_nxt, start_nxt, astd_nxt, d1b_nxt, d2b_nxt} = {lock_r, global_event_mask_bit_r, start_r, astd_r, d1b_r, d2b_r};
    sleep_nxt = sleep_r;
    slpmsk_nxt = slpmsk_r;
    othmsk_nxt = othmsk_r;
    limit_nxt = limit_r;
    saddr_nxt = saddr_r;
    saddr_vld_nxt = saddr_vld_r;
    if (acc_wr && I_PADDR == mra_pkg::OFF_CFG) begin
      lock_nxt = lock_r | wd[mra_pkg::CFG_LOCK];
      astd_nxt = wd[mra_pkg::CFG_ALERT_STD];
      d1b_nxt = wd[mra_pkg::CFG_DIODE1B];
      d2b_nxt = wd[mra_pkg::CFG_DIODE2B];
      if (wd[mra_pkg::CFG_START]) begin
        start_nxt = 1'b1;
        global_event_mask_bit_nxt = 1'b0;
      end
    end
    if (acc_wr && I_PADDR == mra_pkg::OFF_SLEEP) begin
      sleep_nxt = wd[2:0];
    end
    if (acc_wr && !lock_r) begin
      if (I_PADDR == mra_pkg::OFF_SLPMSK) begin
        slpmsk_nxt = wd;
      end
      if (I_PADDR == mra_pkg::OFF_OTHMSK) begin
        othmsk_nxt = wd;
      end
      if (I_PADDR == mra_pkg::OFF_LIMIT) begin
        limit_nxt = wd;
      end
    end
    if (ext_apply) begin
      lock_nxt = 1'b0; // [R09] [R13]
      sleep_nxt = mra_pkg::DEEPEST_SLEEP_STATE; // [R10] [R13]
    end
    if (setup && !saddr_vld_r) begin
      saddr_vld_nxt = 1'b1; // [R14]
      case (asel2_r)
        mra_pkg::ASEL_LOW: saddr_nxt = mra_pkg::SADDR_LOW;
        mra_pkg::ASEL_MID: saddr_nxt = mra_pkg::SADDR_MID;
        mra_pkg::ASEL_HIGH: saddr_nxt = mra_pkg::SADDR_HIGH;
        default: saddr_nxt = mra_pkg::SADDR_MID;
      endcase
    end
  end

  // por initialises setup groups; values stay untouched [R12]
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      {lock_r, start_r, astd_r, d1b_r, d2b_r} <= 5'h00;
      global_event_mask_bit_r <= 1'b1;
      sleep_r <= mra_pkg::DEEPEST_SLEEP_STATE;
      slpmsk_r <= mra_pkg::MASK_RST;
      othmsk_r <= mra_pkg::MASK_RST;
      limit_r <= mra_pkg::LIMIT_RST;
      saddr_r <= 7'h00;
      saddr_vld_r <= 1'b0;
    end else begin
      {lock_r, global_event_mask_bit_r, start_r, astd_r, d1b_r, d2b_r} <= {lock_nxt, global_event_mask_bit_nxt, start_nxt, astd_nxt, d1b_nxt, d2b_nxt};
      sleep_r <= sleep_nxt;
      slpmsk_r <= slpmsk_nxt;
      othmsk_r <= othmsk_nxt;
      limit_r <= limit_nxt;
      saddr_r <= saddr_nxt;
      saddr_vld_r <= saddr_vld_nxt;
    end
  end

  // select sync kept out of reset: first setup after release must see the pin [R14]
  always_ff @(posedge I_MCLK) begin
    asel1_r <= I_ADDR_SEL;
    asel2_r <= asel1_r;
  end

  assign O_SLAVE_ADDR = saddr_r;
  assign O_SLAVE_ADDR_VLD = saddr_vld_r;

  // ==========================================================
  // sticky error status, two copies
  logic [7:0] mcst_r, mcst_nxt, hostst_r, hostst_nxt, eff_mask, ev_set;
  logic mc_rclr;

  always_comb begin
    eff_mask = othmsk_r | {8{global_event_mask_bit_r}};
    if (sleep_r != mra_pkg::SLEEP_RUN) begin
      eff_mask = eff_mask | slpmsk_r;
    end
    if (sleep_r == mra_pkg::DEEPEST_SLEEP_STATE) begin
      eff_mask = eff_mask | mra_pkg::DEEP_FIXED_MASK; // [R10]
    end
    ev_set = I_EVENT & ~eff_mask; // [R22]
    mc_rclr = acc_rd && astd_r && I_PADDR == mra_pkg::OFF_MCST; // [R20]
    mcst_nxt = mcst_r;
    hostst_nxt = hostst_r;
    if (acc_wr && I_PADDR == mra_pkg::OFF_MCST) begin
      mcst_nxt = mcst_r & ~(wd & ~I_EVENT); // [R18] [R19]
    end
    if (mc_rclr) begin
      mcst_nxt = mcst_r & I_EVENT; // [R20]
    end
    if (acc_wr && I_PADDR == mra_pkg::OFF_HOSTST) begin
      hostst_nxt = hostst_r & ~(wd & ~I_EVENT); // [R18] [R19]
    end
    mcst_nxt = mcst_nxt | ev_set; // [R17]
    hostst_nxt = hostst_nxt | ev_set; // [R17]
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      mcst_r <= 8'h00;
      hostst_r <= 8'h00;
    end else begin
      mcst_r <= mcst_nxt;
      hostst_r <= hostst_nxt;
    end
  end

  // ==========================================================
  // 16-bit registers: read freeze and write buffer
  logic [15:0] w16_r [0:1];
  logic [15:0] w16_nxt [0:1];
  logic frz_vld_r, frz_vld_nxt, frz_idx_r, frz_idx_nxt, pnd_vld_r, pnd_vld_nxt, pnd_idx_r, pnd_idx_nxt;
  logic [7:0] frz_hi_r, frz_hi_nxt, pnd_lo_r, pnd_lo_nxt;
  logic hi_nack;

  assign hi_nack = acc_wr && dec[2] && dec[0] && !(pnd_vld_r && pnd_idx_r == dec[1]); // [R06]

  always_comb begin
    w16_nxt = w16_r;
    {frz_vld_nxt, frz_idx_nxt, frz_hi_nxt} = {frz_vld_r, frz_idx_r, frz_hi_r};
    {pnd_vld_nxt, pnd_idx_nxt, pnd_lo_nxt} = {pnd_vld_r, pnd_idx_r, pnd_lo_r};
    if (acc_rd && dec[2]) begin
      if (!dec[0]) begin
        frz_vld_nxt = 1'b1; // [R01] [R03]
        frz_idx_nxt = dec[1];
        frz_hi_nxt = w16_r[dec[1]][15:8];
      end else if (frz_vld_r && frz_idx_r == dec[1]) begin
        frz_vld_nxt = 1'b0; // [R02]
      end
    end
    if (acc_wr && dec[2]) begin
      if (!dec[0]) begin
        pnd_vld_nxt = 1'b1; // [R04] [R05]
        pnd_idx_nxt = dec[1];
        pnd_lo_nxt = wd;
      end else if (!hi_nack) begin
        w16_nxt[dec[1]] = {wd, pnd_lo_r}; // [R04]
        pnd_vld_nxt = 1'b0;
      end
    end
    if (ext_apply) begin
      frz_vld_nxt = 1'b0; // [R23]
      pnd_vld_nxt = 1'b0;
    end
  end

  generate
    for (genvar gi = 0; gi < 2; gi++) begin : g_w16
      always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          w16_r[gi] <= mra_pkg::W16_RST;
        end else begin
          w16_r[gi] <= w16_nxt[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      {frz_vld_r, frz_idx_r, frz_hi_r} <= 10'h000; // [R23]
      {pnd_vld_r, pnd_idx_r, pnd_lo_r} <= 10'h000;
    end else begin
      {frz_vld_r, frz_idx_r, frz_hi_r} <= {frz_vld_nxt, frz_idx_nxt, frz_hi_nxt};
      {pnd_vld_r, pnd_idx_r, pnd_lo_r} <= {pnd_vld_nxt, pnd_idx_nxt, pnd_lo_nxt};
    end
  end

  // ==========================================================
  // round-robin conversion sequencer
  logic [7:0] val_mem [0:mra_pkg::NUM_SLOTS-1];
  logic [4:0] slot_r, slot_nxt;
  logic [16:0] scnt_r, scnt_nxt;
  logic slot_end;

  assign slot_end = (scnt_r == 17'(P_SLOT_CYC - 1));

  always_comb begin
    slot_nxt = slot_r;
    scnt_nxt = scnt_r + 17'h00001;
    if (slot_end) begin
      scnt_nxt = 17'h00000;
      slot_nxt = (slot_r == mra_pkg::SLOT_LAST) ? 5'h00 : slot_r + 5'h01; // [R15]
      if (slot_nxt == mra_pkg::SLOT_Z1B && !d1b_r) begin
        slot_nxt = slot_nxt + 5'h01;
      end
      if (slot_nxt == mra_pkg::SLOT_Z2B && !d2b_r) begin
        slot_nxt = slot_nxt + 5'h01;
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      slot_r <= 5'h00;
      scnt_r <= 17'h00000;
    end else begin
      slot_r <= slot_nxt;
      scnt_r <= scnt_nxt;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (slot_end) begin
      val_mem[slot_r] <= I_CONV_DATA; // [R16]
    end
  end

  assign O_CONV_CHAN = slot_r;

  // ==========================================================
  // APB read data and error
  logic [31:0] prdata_r, prdata_nxt;
  logic unmapped;
  logic [7:0] vidx;

  assign vidx = 8'((I_PADDR - mra_pkg::OFF_VAL_BASE) >> 2);

  always_comb begin
    prdata_nxt = prdata_r;
    unmapped = 1'b0;
    if (setup) begin
      prdata_nxt = 32'h00000000;
      if (I_PADDR[1:0] != 2'b00) begin
        unmapped = 1'b1;
      end else if (dec[2]) begin
        prdata_nxt[7:0] = (dec[0] && frz_vld_r && frz_idx_r == dec[1]) ? frz_hi_r : // [R01]
          (dec[0] ? w16_r[dec[1]][15:8] : w16_r[dec[1]][7:0]);
      end else if (I_PADDR >= mra_pkg::OFF_VAL_BASE && I_PADDR <= mra_pkg::OFF_VAL_END) begin
        prdata_nxt[7:0] = val_mem[vidx[4:0]]; // [R16]
      end else begin
        case (I_PADDR)
          mra_pkg::OFF_CFG: prdata_nxt[5:0] = {d2b_r, d1b_r, start_r, astd_r, global_event_mask_bit_r, lock_r};
          mra_pkg::OFF_SLEEP: prdata_nxt[2:0] = sleep_r;
          mra_pkg::OFF_SLPMSK: prdata_nxt[7:0] = slpmsk_r;
          mra_pkg::OFF_OTHMSK: prdata_nxt[7:0] = othmsk_r;
          mra_pkg::OFF_MCST: prdata_nxt[7:0] = mcst_r;
          mra_pkg::OFF_HOSTST: prdata_nxt[7:0] = hostst_r;
          mra_pkg::OFF_LIMIT: prdata_nxt[7:0] = limit_r;
          mra_pkg::OFF_ADDRST: prdata_nxt[7:0] = {saddr_vld_r, saddr_r};
          mra_pkg::OFF_ID: prdata_nxt[7:0] = mra_pkg::FACTORY_ID;
          default: unmapped = 1'b1;
        endcase
      end
    end
  end

  logic err_r, err_nxt;
  assign err_nxt = setup ? unmapped : err_r;

  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      prdata_r <= 32'h00000000;
      err_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      err_r <= err_nxt;
    end
  end

  assign O_PRDATA = prdata_r;
  assign O_PSLVERR = I_PSEL && I_PENABLE && (err_r || hi_nack); // [R06]

  // ==========================================================
  // checks
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_B);

  sequence s_lo_read;
    acc_rd && dec[2] && !dec[0];
  endsequence
  sequence s_hi_read_frozen;
    acc_rd && dec[2] && dec[0] && frz_vld_r && frz_idx_r == dec[1];
  endsequence

  a_ext_lock: assert property (ext_apply |=> !lock_r) else $error("lock not cleared"); // [R09]
  a_ext_sleep: assert property (ext_apply |=> sleep_r == mra_pkg::DEEPEST_SLEEP_STATE)
    else $error("sleep not deepest"); // [R10]
  a_freeze_take: assert property (s_lo_read |=> frz_vld_r && frz_hi_r == $past(w16_r[dec[1]][15:8]))
    else $error("high byte not frozen"); // [R01]
  a_freeze_release: assert property (s_hi_read_frozen |=> !frz_vld_r) else $error("freeze kept"); // [R02]
  a_hi_commit: assert property (acc_wr && dec[2] && dec[0] && !hi_nack |=>
    w16_r[$past(dec[1])] == {$past(wd), $past(pnd_lo_r)}) else $error("buffered write lost"); // [R04]
  a_hi_refuse: assert property (acc_wr && dec[2] && dec[0] && !pnd_vld_r |-> O_PSLVERR)
    else $error("high write accepted"); // [R06]
  a_mc_sticky: assert property (!(acc_wr && I_PADDR == mra_pkg::OFF_MCST) && !mc_rclr |=>
    (mcst_r & $past(mcst_r)) == $past(mcst_r)) else $error("status bit dropped"); // [R17]
  a_active_holds: assert property (##1 ((mcst_r & $past(I_EVENT) & $past(mcst_r)) == ($past(I_EVENT) & $past(mcst_r))))
    else $error("active event cleared"); // [R18]
  a_host_indep: assert property (acc_wr && I_PADDR == mra_pkg::OFF_MCST |=>
    (hostst_r & $past(hostst_r)) == $past(hostst_r)) else $error("host copy cleared"); // [R19]
  a_mask_blocks: assert property (##1 ((mcst_r & ~$past(mcst_r) & $past(eff_mask)) == 8'h00))
    else $error("masked event set status"); // [R22]
  a_por_drive: assert property ($rose(pin_st_r == ST_RUN) |-> $past(O_RSTPIN_OE, 1) && !O_RSTPIN_OE)
    else $error("pin drive wrong"); // [R08]
  a_addr_fixed: assert property (saddr_vld_r |=> saddr_vld_r && $stable(saddr_r))
    else $error("slave address changed"); // [R14]
  a_slot_bound: assert property (scnt_r < 17'(P_SLOT_CYC) && slot_r <= mra_pkg::SLOT_LAST)
    else $error("sequencer out of range"); // [R15]
endmodule

// [test/mra_master.sv]
// Purpose: APB master and reset pin model facing mra_top
// Assumes: single master, pull-up on the reset pin
// Notes: all changes by non-blocking assignment after a rising edge
`timescale 1ns/1ps
module mra_master (
  input wire logic i_clk,
  input wire logic i_pready,
  input wire logic i_pslverr,
  input wire logic [31:0] i_prdata,
  input wire logic i_pin_oe,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic o_pin_b
);
  logic ext_low = 1'b0;
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end
  // ==========================================================
  // open-drain pin, pulled up when nobody drives
  assign o_pin_b = !(i_pin_oe || ext_low);
  // one master only, so no other master interleaves 16-bit halves
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (i_pready !== 1'b1);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask
  // pulse held for a whole number of cycles
  task automatic pin_low(input int cyc);
    @(posedge i_clk);
    ext_low <= 1'b1;
    repeat (cyc) @(posedge i_clk);
    ext_low <= 1'b0;
  endtask
endmodule

// [test/tb.sv]
// Purpose: self-checking bench of mra_top
// Assumes: short conversion slots of 20 cycles
// Notes: expectations derive from the register map and the rules
`timescale 1ns/1ps
module tb;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, pin, oe, vld, e, pdrv;
  logic [7:0] paddr, ev, conv, lo, hi, lo2, hi2;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] asel = 2'h0;
  logic [6:0] saddr;
  logic [4:0] chan;
  logic [7:0] evt = 8'h00;
  int err_total = 0;
  int total_checks = 0;
  int seed = 32'h53f5690b;
  int n;
  logic [7:0] pa[6] = '{8'h00, 8'h04, 8'h18, 8'h10, 8'h20, 8'hfc};
  logic [7:0] pv[6] = '{8'h02, 8'h05, 8'hff, 8'h00, 8'h00, 8'h5a};
  mra_top #(.P_SLOT_CYC(20)) uut (.I_MCLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_RSTPIN_B(pin), .O_RSTPIN_B(pdrv), .O_RSTPIN_OE(oe), .I_ADDR_SEL(asel),
    .O_SLAVE_ADDR(saddr), .O_SLAVE_ADDR_VLD(vld), .I_EVENT(evt), .I_CONV_DATA(conv), .O_CONV_CHAN(chan));
  mra_master u_m (.i_clk(clk), .i_pready(pready), .i_pslverr(pslverr), .i_prdata(prdata), .i_pin_oe(oe),
    .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .o_pin_b(pin));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial conv = 8'h00;
  always @(posedge clk) conv <= 8'ha0 + {3'h0, chan};
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_m.xfer(1'b1, a, {24'h0, d}, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    u_m.xfer(1'b0, a, 32'h0, q, e);
  endtask
  function automatic logic [6:0] addr_of(input logic [1:0] s);
    return (s == 2'h0) ? 7'h2c : ((s == 2'h1) ? 7'h2e : 7'h2d);
  endfunction
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    end_of_test;
  end
  // ==========================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    for (int s = 0; s < 3; s++) begin
      rst_b <= 1'b0;
      asel <= s[1:0];
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      wr(8'h24, 8'h11);
      chk(32'(e), 1);
      chk(32'(saddr), 32'(addr_of(s[1:0])));
      chk(32'(vld), 1);
      chk(32'(oe), 1);
      chk(32'(pdrv), 0);
      foreach (pa[i]) begin
        rd(pa[i]);
        chk(q, 32'(pv[i]));
      end
      n = 0;
      while (oe !== 1'b0 && n < 1000) begin
        @(posedge clk);
        n++;
      end
      chk(32'(oe), 0);
    end
    repeat (300) @(posedge clk);
    rd(8'hf1);
    chk({q[30:0], e}, 1);
    lo = 8'($random(seed));
    hi = 8'($random(seed));
    lo2 = ~lo;
    hi2 = ~hi;
    wr(8'h20, lo);
    wr(8'h24, hi);
    rd(8'h20);
    chk(q, 32'(lo));
    wr(8'h20, lo2);
    rd(8'h20);
    chk(q, 32'(lo));
    wr(8'h24, hi2);
    rd(8'h24);
    chk(q, 32'(hi));
    rd(8'h24);
    chk(q, 32'(hi2));
    rd(8'h20);
    wr(8'h28, lo);
    wr(8'h2c, hi);
    wr(8'h20, lo);
    wr(8'h24, hi);
    rd(8'h28);
    rd(8'h24);
    chk(q, 32'(hi));
    wr(8'h20, lo2);
    wr(8'h28, lo2);
    wr(8'h24, hi2);
    chk(32'(e), 1);
    wr(8'h04, 8'h00);
    evt <= 8'h01;
    rd(8'h10);
    chk(q, 0);
    // run state first, now the start bit
    wr(8'h00, 8'h08);
    ev = 8'($random(seed)) | 8'h01;
    evt <= ev;
    wr(8'h10, 8'hff);
    rd(8'h10);
    chk(q, 32'(ev));
    evt <= 8'h00;
    rd(8'h10);
    chk(q, 32'(ev));
    wr(8'h10, 8'hff);
    rd(8'h10);
    chk(q, 0);
    wr(8'h0c, 8'hff);
    rd(8'h14);
    chk(q, 32'(ev));
    wr(8'h14, 8'hff);
    wr(8'h0c, 8'h00);
    wr(8'h00, 8'h04);
    evt <= ev;
    @(posedge clk);
    evt <= 8'h00;
    rd(8'h10);
    chk(q, 32'(ev));
    rd(8'h10);
    chk(q, 0);
    rd(8'h14);
    chk(q, 32'(ev));
    wr(8'h0c, 8'h33);
    wr(8'h00, 8'h01);
    u_m.pin_low(40);
    repeat (250) @(posedge clk);
    rd(8'h00);
    chk(q, 32'h09);
    u_m.pin_low(100);
    repeat (85) @(posedge clk);
    rd(8'h00);
    chk(q, 32'h09);
    repeat (25) @(posedge clk);
    rd(8'h00);
    chk(q, 32'h08);
    rd(8'h04);
    chk(q, 32'h05);
    rd(8'h0c);
    chk(q, 32'h33);
    for (int k = 0; k < 21; k++) begin
      if (k != 2 && k != 4) begin
        rd(8'h40 + 8'(4 * k));
        chk(q, 32'(8'ha0 + 8'(k)));
      end
    end
    // second diodes enabled: skipped slots now convert
    wr(8'h00, 8'h38);
    repeat (500) @(posedge clk);
    rd(8'h48);
    chk(q, 32'h000000a2);
    rd(8'h50);
    chk(q, 32'h000000a4);
    end_of_test;
  end
endmodule
